// ==== logic/edid_channel_pkg.sv ====
// Constants shared by the display channel logic.
package edid_channel_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] CHANNEL_CONTROL_ADDR   = 8'hC8;
    localparam logic [7:0] CHANNEL_BYTE_DATA_ADDR = 8'hC9;

    // =========================================================
    // Control register fields
    localparam int STREAM_ENABLE_BIT        = 0;
    localparam int BYTE_TAKEN_BIT           = 1;
    localparam int PASSTHROUGH_SELECT_BIT   = 2;
    localparam int TWOWIRE_DETECT_ENABLE_BIT = 3;
    localparam logic [3:0] CHANNEL_CONTROL_RESET   = 4'h0;
    localparam logic [7:0] CHANNEL_BYTE_DATA_RESET = 8'h00;

    // =========================================================
    // Stream framing
    localparam int PACKET_BITS         = 9;
    localparam int FRAME_BYTES         = 128;
    localparam int IDLE_VSYNC_PULSES   = 128;
    localparam logic [3:0] NULL_PHASE  = 4'(PACKET_BITS - 1);
    localparam logic [7:0] IDLE_LAST   = 8'(IDLE_VSYNC_PULSES - 1);

    // =========================================================
    // Timing
    localparam int CLK_MHZ            = 25;
    localparam int BIT_VALID_US       = 30;
    localparam int BIT_VALID_CYCLES   = BIT_VALID_US * CLK_MHZ;
    localparam int VSYNC_LOSS_US      = 100000;
    localparam int VSYNC_LOSS_CYCLES  = VSYNC_LOSS_US * CLK_MHZ;

    // =========================================================
    // State encodings
    typedef enum logic [0:0]
    {
        STREAM_IDLE = 1'b0,
        STREAM_SEND = 1'b1
    } stream_type;

    typedef enum logic [1:0]
    {
        DIR_NONE   = 2'b00,
        DIR_TO_BUS = 2'b01,
        DIR_TO_CH  = 2'b10,
        DIR_SETTLE = 2'b11
    } dir_type;

endpackage

// ==== logic/edge_sync.sv ====
// Three-stage input synchroniser with agreement filter and edge pulses.
`timescale 1ns/10ps
module edge_sync
#(
    parameter logic INIT = 1'b1
)
(
    input  wire logic CLK,
    input  wire logic RSTN,
    input  wire logic d,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } sync_type;

    sync_type q;
    sync_type next_q;

    // =========================================================
    // A change counts once the second and third stages agree.
    always_comb
    begin
        next_q = q;
        next_q.s1 = d;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.rise = 1'b0;
        next_q.fall = 1'b0;
        if (q.s2 == q.s3 && q.s3 != q.level)
        begin
            next_q.level = q.s3;
            next_q.rise = q.s3;
            next_q.fall = !q.s3;
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            q <= {INIT, INIT, INIT, INIT, 1'b0, 1'b0};
        end
        else
        begin
            q <= next_q;
        end
    end

    assign level = q.level;
    assign rise  = q.rise;
    assign fall  = q.fall;

endmodule

// ==== logic/edid_channel.sv ====
// Display identification channel: sync-clocked byte stream and two-wire passthrough.
//
// Behaviour
// R1: Stream mode shifts one bit per sync rise.
// R2: Each byte is a nine-bit packet, null last.
// R3: Frame bytes keep streaming while stream mode lasts.
// R4: Clock falling edge enters two-wire mode, releases data.
// R5: Two-wire mode joins channel lines to bus pins.
// R6: 128 idle sync pulses return to stream mode.
// R7: Reset gives stream mode, passthrough select zero.
// R8: Software loads first byte before enabling.
// R9: First sync rise loads byte, later rises shift.
// R10: Without sync pulses the data line is released.
// R11: Byte transfer sets taken flag; enables raise interrupt.
// R12: Software reloads byte, then clears taken flag.
// R13: Interrupt request ORs uart flags and taken flag.
// R14: Bit valid within 30 us, held till next rise.
// R15: Host holds sync high 20 us, max 25 kHz.
// R16: Control bit 3 enables two-wire detection.
// R17: Software may force passthrough select on or off.
// R18: Control bit 0 enables the whole channel; here it gates only the stream side, two-wire detection runs without it.
// R19: Software writes no ones to upper control bits.
// R20: Control register read/write, bit addressable, low bits reset.
// R21: Byte data register read/write holds next byte.
// R22: Bytes go out most significant bit first.
// R23: Sync and clock inputs synchronised, edge detected.
`timescale 1ns/10ps
module edid_channel
    import edid_channel_pkg::*;
#(
    parameter int VSYNC_LOSS_CYCLES_P = edid_channel_pkg::VSYNC_LOSS_CYCLES
)
(
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic       VSYNC_CLK,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_BIT_WR,
    input  wire logic [2:0] SFR_BIT_SEL,
    input  wire logic       SFR_BIT_VAL,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       UART_RX_FLAG,
    input  wire logic       UART_TX_FLAG,
    input  wire logic       SERIAL_IRQ_ENABLE,
    input  wire logic       GLOBAL_IRQ_ENABLE,
    output logic            SERIAL_IRQ,
    input  wire logic       CH_CLK_IN,
    input  wire logic       CH_DATA_IN,
    output logic            CH_DATA_OUT,
    output logic            CH_DATA_OE,
    input  wire logic       BUS_DATA_IN,
    output logic            BUS_DATA_OUT,
    output logic            BUS_DATA_OE,
    output logic            BUS_CLK_OUT,
    output logic            BUS_CLK_OE
);

    localparam int LOSS_W = $clog2(VSYNC_LOSS_CYCLES_P + 1);

    generate
        if (VSYNC_LOSS_CYCLES_P < 2)
        begin : bad_loss
            $error("VSYNC_LOSS_CYCLES_P must be at least 2");
        end
    endgenerate

    typedef struct packed
    {
        logic              stream_enable;
        logic              byte_taken_flag;
        logic              passthrough_select;
        logic              twowire_detect_enable;
        logic [7:0]        byte_data;
        logic [7:0]        shifter;
        logic [3:0]        phase;
        stream_type        stream;
        logic [7:0]        idle_pulses;
        logic [LOSS_W-1:0] loss_cnt;
        dir_type           dir;
        logic [7:0]        rdata;
        logic              data_oe;
        logic              bus_data_oe;
        logic              bus_clk_oe;
        logic              irq;
        logic              low_level;
    } state_type;

    state_type q;
    state_type next_q;

    logic link_toggle;
    logic vs_rise;
    logic vs_fall;
    logic clk_level;
    logic clk_rise;
    logic clk_fall;
    logic chd_level;
    logic busd_level;
    logic vs_event;
    logic ctrl_wr;
    logic [3:0] ctrl_wval;
    logic load_event;
    logic lost;

    // =========================================================
    // Link domain: each sync rising edge flips a toggle.
    always_ff @(posedge VSYNC_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            link_toggle <= 1'b0;
        end
        else
        begin
            link_toggle <= !link_toggle;
        end
    end

    // =========================================================
    // Input synchronisers.
    edge_sync #(.INIT(1'b0)) vs_sync
    (
        .CLK   (CLK),
        .RSTN  (RSTN),
        .d     (link_toggle),
        .level (),
        .rise  (vs_rise),
        .fall  (vs_fall)
    );

    edge_sync #(.INIT(1'b1)) chclk_sync
    (
        .CLK   (CLK),
        .RSTN  (RSTN),
        .d     (CH_CLK_IN),
        .level (clk_level),
        .rise  (clk_rise),
        .fall  (clk_fall)
    );

    edge_sync #(.INIT(1'b1)) chdata_sync
    (
        .CLK   (CLK),
        .RSTN  (RSTN),
        .d     (CH_DATA_IN),
        .level (chd_level),
        .rise  (),
        .fall  ()
    );

    edge_sync #(.INIT(1'b1)) busdata_sync
    (
        .CLK   (CLK),
        .RSTN  (RSTN),
        .d     (BUS_DATA_IN),
        .level (busd_level),
        .rise  (),
        .fall  ()
    );

    assign vs_event = vs_rise | vs_fall; // see R23
    assign lost     = q.loss_cnt == LOSS_W'(VSYNC_LOSS_CYCLES_P);

    // =========================================================
    // Register writes, whole byte or single bit.
    always_comb
    begin
        ctrl_wval = {q.twowire_detect_enable, q.passthrough_select, q.byte_taken_flag, q.stream_enable};
        ctrl_wr = 1'b0;
        if (SFR_WR && SFR_ADDR == CHANNEL_CONTROL_ADDR)
        begin
            ctrl_wr = 1'b1;
            ctrl_wval = SFR_WDATA[3:0];
        end
        else if (SFR_BIT_WR && SFR_ADDR == CHANNEL_CONTROL_ADDR && !SFR_BIT_SEL[2])
        begin
            ctrl_wr = 1'b1; // see R20
            ctrl_wval[SFR_BIT_SEL[1:0]] = SFR_BIT_VAL;
        end
    end

    assign load_event = vs_event && q.stream_enable && !q.passthrough_select
                        && (q.stream == STREAM_IDLE || lost || q.phase == NULL_PHASE);

    // =========================================================
    // Next state.
    always_comb
    begin
        next_q = q;
        next_q.low_level = 1'b0;
        if (ctrl_wr)
        begin
            next_q.stream_enable = ctrl_wval[STREAM_ENABLE_BIT]; // see R18
            next_q.byte_taken_flag = ctrl_wval[BYTE_TAKEN_BIT];
            next_q.passthrough_select = ctrl_wval[PASSTHROUGH_SELECT_BIT]; // see R17
            next_q.twowire_detect_enable = ctrl_wval[TWOWIRE_DETECT_ENABLE_BIT]; // see R16
        end
        if (SFR_WR && SFR_ADDR == CHANNEL_BYTE_DATA_ADDR)
        begin
            next_q.byte_data = SFR_WDATA; // see R21
        end

        // Stream side.
        if (vs_event)
        begin
            next_q.loss_cnt = '0;
        end
        else if (q.loss_cnt != LOSS_W'(VSYNC_LOSS_CYCLES_P))
        begin
            next_q.loss_cnt = q.loss_cnt + 1'b1;
        end
        if (!q.stream_enable || q.passthrough_select || (lost && !vs_event))
        begin
            next_q.stream = STREAM_IDLE; // see R10
            next_q.phase = '0;
            if (!q.passthrough_select)
            begin
                next_q.data_oe = 1'b0;
            end
        end
        else if (vs_event)
        begin
            unique case (lost ? STREAM_IDLE : q.stream)
                STREAM_IDLE:
                begin
                    next_q.shifter = q.byte_data; // see R9
                    next_q.stream = STREAM_SEND;
                    next_q.phase = '0;
                    next_q.data_oe = 1'b0;
                end
                STREAM_SEND:
                begin
                    if (q.phase == NULL_PHASE)
                    begin
                        next_q.data_oe = 1'b1; // see R2
                        next_q.shifter = q.byte_data; // see R3
                        next_q.phase = '0;
                    end
                    else
                    begin
                        next_q.data_oe = !q.shifter[7]; // see R1, R22, R14
                        next_q.shifter = {q.shifter[6:0], 1'b0};
                        next_q.phase = q.phase + 1'b1;
                    end
                end
            endcase
        end
        else if (q.stream == STREAM_IDLE)
        begin
            next_q.data_oe = 1'b0; // see R10
        end
        if (load_event)
        begin
            next_q.byte_taken_flag = 1'b1; // see R11
        end

        // Mode switching between stream and two-wire.
        if (q.passthrough_select)
        begin
            if (clk_rise || clk_fall)
            begin
                next_q.idle_pulses = '0;
            end
            else if (vs_event)
            begin
                next_q.idle_pulses = q.idle_pulses + 1'b1;
                if (q.idle_pulses == IDLE_LAST && !ctrl_wr)
                begin
                    next_q.passthrough_select = 1'b0; // see R6
                end
            end
        end
        else
        begin
            next_q.idle_pulses = '0;
            if (clk_fall && q.twowire_detect_enable && !ctrl_wr)
            begin
                next_q.passthrough_select = 1'b1; // see R4
                next_q.data_oe = 1'b0;
            end
        end

        // Two-wire passthrough with direction ownership.
        next_q.bus_clk_oe = q.passthrough_select && !clk_level; // see R5
        if (!q.passthrough_select)
        begin
            next_q.dir = DIR_NONE;
            next_q.bus_data_oe = 1'b0;
        end
        else
        begin
            unique case (q.dir)
                DIR_NONE:
                begin
                    if (!chd_level)
                    begin
                        next_q.dir = DIR_TO_BUS;
                        next_q.bus_data_oe = 1'b1; // see R5
                    end
                    else if (!busd_level)
                    begin
                        next_q.dir = DIR_TO_CH;
                        next_q.data_oe = 1'b1;
                    end
                end
                DIR_TO_BUS:
                begin
                    if (chd_level)
                    begin
                        next_q.dir = DIR_SETTLE;
                        next_q.bus_data_oe = 1'b0;
                    end
                end
                DIR_TO_CH:
                begin
                    if (busd_level)
                    begin
                        next_q.dir = DIR_SETTLE;
                        next_q.data_oe = 1'b0;
                    end
                end
                DIR_SETTLE:
                begin
                    if (chd_level && busd_level)
                    begin
                        next_q.dir = DIR_NONE;
                    end
                end
            endcase
        end

        next_q.irq = (UART_RX_FLAG || UART_TX_FLAG || q.byte_taken_flag)
                     && SERIAL_IRQ_ENABLE && GLOBAL_IRQ_ENABLE; // see R13

        if (SFR_ADDR == CHANNEL_CONTROL_ADDR)
        begin
            next_q.rdata = {4'h0, q.twowire_detect_enable, q.passthrough_select,
                            q.byte_taken_flag, q.stream_enable};
        end
        else if (SFR_ADDR == CHANNEL_BYTE_DATA_ADDR)
        begin
            next_q.rdata = q.byte_data;
        end
        else
        begin
            next_q.rdata = 8'h00;
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            q <= '0; // see R7
            q.stream_enable <= CHANNEL_CONTROL_RESET[STREAM_ENABLE_BIT];
            q.byte_data <= CHANNEL_BYTE_DATA_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign SFR_RDATA    = q.rdata;
    assign SERIAL_IRQ   = q.irq;
    assign CH_DATA_OUT  = q.low_level;
    assign CH_DATA_OE   = q.data_oe;
    assign BUS_DATA_OUT = q.low_level;
    assign BUS_DATA_OE  = q.bus_data_oe;
    assign BUS_CLK_OUT  = q.low_level;
    assign BUS_CLK_OE   = q.bus_clk_oe;

    // =========================================================
    // Checks.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    sequence send_edge;
        vs_event && q.stream == STREAM_SEND && q.stream_enable && !q.passthrough_select
        && !lost && !(clk_fall && q.twowire_detect_enable);
    endsequence

    load_taken_a: assert property ( // see R9
        load_event |=> q.byte_taken_flag && q.shifter == $past(q.byte_data))
        else $error("byte not loaded or taken flag not set");

    msb_first_a: assert property ( // see R22
        send_edge and (q.phase != NULL_PHASE) |=> CH_DATA_OE == !$past(q.shifter[7]))
        else $error("stream bit does not match shifter msb");

    null_bit_a: assert property ( // see R2
        send_edge and (q.phase == NULL_PHASE) |=> CH_DATA_OE && q.phase == 4'h0)
        else $error("null separator bit not driven low");

    twowire_entry_a: assert property ( // see R4
        clk_fall && q.twowire_detect_enable && !q.passthrough_select && !ctrl_wr
        |=> q.passthrough_select ##1 !CH_DATA_OE || q.dir == DIR_TO_CH)
        else $error("two-wire mode not entered on clock fall");

    clock_mirror_a: assert property ( // see R5
        q.passthrough_select && !clk_level |=> BUS_CLK_OE)
        else $error("channel clock not passed to bus clock");

    idle_revert_a: assert property ( // see R6
        q.passthrough_select && vs_event && q.idle_pulses == IDLE_LAST && !clk_rise && !clk_fall
        && !ctrl_wr |=> !q.passthrough_select)
        else $error("no return to stream mode after idle pulses");

    disabled_release_a: assert property ( // see R18
        !q.stream_enable && !q.passthrough_select ##1 !q.passthrough_select |=> !CH_DATA_OE)
        else $error("data line driven while channel disabled");

    loss_release_a: assert property ( // see R10
        q.loss_cnt == LOSS_W'(VSYNC_LOSS_CYCLES_P) && !q.passthrough_select |=> !CH_DATA_OE)
        else $error("data line not released without sync");

    irq_share_a: assert property ( // see R13
        (q.byte_taken_flag || UART_RX_FLAG) && SERIAL_IRQ_ENABLE && GLOBAL_IRQ_ENABLE |=> SERIAL_IRQ)
        else $error("shared interrupt request missing");

endmodule

// ==== dv/host_card_model.sv ====
// Host video card model: sync pulses on its own link clock and channel line pulls.
`timescale 1ns/10ps
module host_card_model
(
    output logic vsync,
    output logic clk_pull,
    output logic data_pull
);
    logic lclk;

    // =========================================================
    // Link timebase
    initial
    begin
        vsync     = 1'b0;
        clk_pull  = 1'b0;
        data_pull = 1'b0;
        lclk      = 1'b0;
        #7;
        forever #16 lclk = ~lclk;
    end

    // =========================================================
    // One sync pulse; sync stands low between pulses.
    task automatic pulse();
        repeat (12) @(posedge lclk);
        vsync = 1'b1;
        repeat (12) @(posedge lclk);
        vsync = 1'b0;
    endtask

    // =========================================================
    // Channel line pulls.
    task automatic pull_clk(logic v);
        clk_pull = v;
    endtask

    task automatic pull_data(logic v);
        data_pull = v;
    endtask
endmodule

// ==== dv/edid_channel_tb_top.sv ====
// Self-checking bench for the display identification channel.
`timescale 1ns/10ps
module edid_channel_tb_top;
    import edid_channel_pkg::*;
    typedef struct {string nm; int src; logic [7:0] val;} note_type;
    logic       CLK, RSTN, VSYNC_CLK, SFR_WR, SFR_BIT_WR, SFR_BIT_VAL;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, b, cur;
    logic [2:0] SFR_BIT_SEL;
    logic       UART_RX_FLAG, UART_TX_FLAG, SERIAL_IRQ_ENABLE, GLOBAL_IRQ_ENABLE, SERIAL_IRQ;
    logic       CH_CLK_IN, CH_DATA_IN, CH_DATA_OUT, CH_DATA_OE, BUS_DATA_IN, BUS_DATA_OUT;
    logic       BUS_DATA_OE, BUS_CLK_OUT, BUS_CLK_OE, clk_pull, data_pull, look, bus_pull;
    logic [4:0] obs;
    note_type   nt;
    note_type   notes[$];
    int         n_fail, checked, cycles, seed, i, k;

    assign CH_CLK_IN   = ~clk_pull;
    assign CH_DATA_IN  = ~(CH_DATA_OE | data_pull);
    assign BUS_DATA_IN = ~(BUS_DATA_OE | bus_pull);
    assign obs         = {BUS_DATA_OE, BUS_CLK_OE, SERIAL_IRQ, CH_DATA_IN, 1'b0};

    edid_channel #(.VSYNC_LOSS_CYCLES_P(200)) dut
    (
        .CLK(CLK), .RSTN(RSTN), .VSYNC_CLK(VSYNC_CLK), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_BIT_WR(SFR_BIT_WR), .SFR_BIT_SEL(SFR_BIT_SEL),
        .SFR_BIT_VAL(SFR_BIT_VAL), .SFR_RDATA(SFR_RDATA), .UART_RX_FLAG(UART_RX_FLAG),
        .UART_TX_FLAG(UART_TX_FLAG), .SERIAL_IRQ_ENABLE(SERIAL_IRQ_ENABLE),
        .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .SERIAL_IRQ(SERIAL_IRQ), .CH_CLK_IN(CH_CLK_IN),
        .CH_DATA_IN(CH_DATA_IN), .CH_DATA_OUT(CH_DATA_OUT), .CH_DATA_OE(CH_DATA_OE),
        .BUS_DATA_IN(BUS_DATA_IN), .BUS_DATA_OUT(BUS_DATA_OUT), .BUS_DATA_OE(BUS_DATA_OE),
        .BUS_CLK_OUT(BUS_CLK_OUT), .BUS_CLK_OE(BUS_CLK_OE)
    );

    host_card_model host
    (
        .vsync(VSYNC_CLK),
        .clk_pull(clk_pull),
        .data_pull(data_pull)
    );

    always #20 CLK = ~CLK;

    // =========================================================
    // Shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic note(string nm, int src, logic [7:0] v);
        notes.push_back('{nm, src, v});
        look = 1'b1;
        tick(1);
        look = 1'b0;
        tick(1);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] v, string nm);
        SFR_ADDR = a;
        tick(1);
        note(nm, 0, v);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        SFR_ADDR  = a;
        SFR_WDATA = d;
        SFR_WR    = 1'b1;
        tick(1);
        SFR_WR = 1'b0;
        tick(1);
    endtask

    task automatic bw(int sel, logic v);
        SFR_ADDR    = CHANNEL_CONTROL_ADDR;
        SFR_BIT_SEL = 3'(sel);
        SFR_BIT_VAL = v;
        SFR_BIT_WR  = 1'b1;
        tick(1);
        SFR_BIT_WR = 1'b0;
        tick(1);
    endtask

    task automatic vs(int n);
        repeat (n) host.pulse();
        tick(2);
    endtask

    // =========================================================
    // Output watcher and timeout
    always @(posedge CLK)
    begin
        cycles++;
        if (look)
        begin
            nt = notes.pop_front();
            if (nt.src == 0)
                check(nt.nm, SFR_RDATA, nt.val);
            else
                check(nt.nm, {7'h00, obs[nt.src]}, nt.val);
        end
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    // =========================================================
    // Main sequence
    initial
    begin
        {CLK, RSTN, SFR_WR, SFR_BIT_WR, SFR_BIT_VAL, look, bus_pull} = 7'h00;
        {SFR_ADDR, SFR_WDATA, SFR_BIT_SEL} = 19'h00000;
        {UART_RX_FLAG, UART_TX_FLAG, SERIAL_IRQ_ENABLE, GLOBAL_IRQ_ENABLE} = 4'h0;
        n_fail = 0;
        checked = 0;
        cycles = 0;
        seed = 32'h7BA44751;
        repeat (8) @(posedge CLK);
        #1;
        RSTN = 1'b1;
        rd(CHANNEL_CONTROL_ADDR, 8'h00, "control_reset");
        rd(8'hC7, 8'h00, "unmapped");
        note("line_reset", 1, 8'h01);
        b = 8'($random(seed));
        wr(CHANNEL_BYTE_DATA_ADDR, b);
        rd(CHANNEL_BYTE_DATA_ADDR, b, "byte_data");
        SERIAL_IRQ_ENABLE = 1'b1;
        GLOBAL_IRQ_ENABLE = 1'b1;
        wr(CHANNEL_CONTROL_ADDR, 8'h01);
        note("irq_idle", 2, 8'h00);
        vs(1);
        note("first_load_line", 1, 8'h01);
        rd(CHANNEL_CONTROL_ADDR, 8'h03, "taken_flag");
        note("irq_taken", 2, 8'h01);
        for (k = 0; k < 2; k++)
        begin
            cur = b;
            b = 8'($random(seed));
            wr(CHANNEL_BYTE_DATA_ADDR, b);
            bw(BYTE_TAKEN_BIT, 1'b0);
            note("irq_ack", 2, 8'h00);
            for (i = 7; i >= 0; i--)
            begin
                vs(1);
                note("stream_bit", 1, {7'h00, cur[i]});
            end
            vs(1);
            note("null_bit", 1, 8'h00);
            rd(CHANNEL_CONTROL_ADDR, 8'h03, "reload_flag");
        end
        wr(CHANNEL_CONTROL_ADDR, 8'h00);
        vs(1);
        note("stream_off", 1, 8'h01);
        UART_RX_FLAG = 1'b1;
        tick(2);
        note("irq_rx", 2, 8'h01);
        UART_RX_FLAG = 1'b0;
        UART_TX_FLAG = 1'b1;
        tick(2);
        note("irq_tx", 2, 8'h01);
        GLOBAL_IRQ_ENABLE = 1'b0;
        tick(2);
        note("irq_masked", 2, 8'h00);
        UART_TX_FLAG = 1'b0;
        bw(TWOWIRE_DETECT_ENABLE_BIT, 1'b1);
        host.pull_clk(1'b1);
        tick(8);
        rd(CHANNEL_CONTROL_ADDR, 8'h0C, "enter_twowire");
        note("bus_clk_low", 3, 8'h01);
        host.pull_clk(1'b0);
        tick(8);
        note("bus_clk_free", 3, 8'h00);
        host.pull_data(1'b1);
        tick(8);
        note("bus_data_low", 4, 8'h01);
        host.pull_data(1'b0);
        tick(8);
        note("bus_data_free", 4, 8'h00);
        bus_pull = 1'b1;
        tick(8);
        note("ch_data_low", 1, 8'h00);
        bus_pull = 1'b0;
        tick(8);
        note("ch_data_free", 1, 8'h01);
        vs(127);
        rd(CHANNEL_CONTROL_ADDR, 8'h0C, "hold_twowire");
        vs(1);
        rd(CHANNEL_CONTROL_ADDR, 8'h08, "revert_stream");
        wr(CHANNEL_CONTROL_ADDR, 8'h00);
        host.pull_clk(1'b1);
        tick(8);
        rd(CHANNEL_CONTROL_ADDR, 8'h00, "no_detect");
        host.pull_clk(1'b0);
        tick(8);
        bw(PASSTHROUGH_SELECT_BIT, 1'b1);
        rd(CHANNEL_CONTROL_ADDR, 8'h04, "force_on");
        bw(5, 1'b0);
        rd(CHANNEL_CONTROL_ADDR, 8'h04, "upper_bit");
        bw(PASSTHROUGH_SELECT_BIT, 1'b0);
        rd(CHANNEL_CONTROL_ADDR, 8'h00, "force_off");
        tick(4);
        conclude();
    end
endmodule
